// ==== paged_gamma_config_bank_test.sv ====
// testbench: register access, table, mapping and pattern checks
`timescale 1ns/1ps
`default_nettype none
module paged_gamma_config_bank_test;
  import pgcb_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, tmo;
  logic        pready, pslverr, gate_even, subpix_vld;
  logic        pattern_active, link_video_mode;
  logic [11:0] paddr, chan_idx, subpix_idx;
  logic [31:0] pwdata, prdata, q;
  logic [6:0]  gamma_a_idx, gamma_b_idx;
  logic [7:0]  gamma_a_q, gamma_b_q, cmd_page;
  logic [2:0]  zz_type;
  logic [9:0]  pix_x;
  logic [23:0] pattern_rgb;
  logic        e;
  int          err_count, total_checks;
  logic [23:0] pat [8] = '{24'hFFFFFF, 24'h000000, 24'hFF0000,
    24'h00FF00, 24'h0000FF, PGCB_GRAY128, PGCB_GRAY127, 24'h00FFFF};

  pgcb_bank pgcb_bank_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gamma_a_idx(gamma_a_idx),
    .gamma_b_idx(gamma_b_idx), .gamma_a_q(gamma_a_q),
    .gamma_b_q(gamma_b_q), .chan_idx(chan_idx), .gate_even(gate_even),
    .subpix_idx(subpix_idx), .subpix_vld(subpix_vld),
    .zz_type(zz_type), .pix_x(pix_x), .pattern_rgb(pattern_rgb),
    .pattern_active(pattern_active),
    .link_video_mode(link_video_mode), .cmd_page(cmd_page));
  pgcb_host pgcb_host_i (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .tmo(tmo));

  always #12.5 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (tmo === 1'b1)
      err_count++;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] a, input logic [7:0] d);
    pgcb_host_i.xfer(1'b1, PGCB_OFS_CMD, {16'h0, a, d}, q, e);
  endtask

  task automatic ctrl(input logic [8:0] v);
    pgcb_host_i.xfer(1'b1, PGCB_OFS_CTRL, {23'h0, v}, q, e);
  endtask

  task automatic look();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic map(input logic ev, input logic [11:0] ch,
                     input logic [11:0] ix, input logic v);
    @(posedge pclk);
    gate_even <= ev;
    chan_idx <= ch;
    look();
    chk(subpix_vld, v);
    if (v)
      chk(subpix_idx, ix);
  endtask

  initial begin
    {pclk, presetn, gate_even} = 3'b000;
    ce = 1'b1;
    {gamma_a_idx, gamma_b_idx, chan_idx, pix_x} = 36'h0;
    {err_count, total_checks} = 64'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    look();
    chk(gamma_a_q, PGCB_GAMMA_RST);
    chk(gamma_b_q, PGCB_GAMMA_RST);
    chk(link_video_mode, 1'b1);
    pgcb_host_i.page(PGCB_PAGE_A);
    look();
    chk(cmd_page, PGCB_PAGE_A);
    cmd(PGCB_GAMMA_LAST, 8'h5A);
    cmd(8'h00, 8'hA5);
    gamma_a_idx <= 7'h7F;
    look();
    chk(gamma_a_q, 8'h5A);
    ctrl(9'h100);
    pgcb_host_i.xfer(1'b0, PGCB_OFS_STAT, 32'h0, q, e);
    chk(q[11:0], 12'h809);
    chk(link_video_mode, 1'b0);
    pgcb_host_i.page(PGCB_PAGE_B);
    cmd(PGCB_GAMMA_LAST, 8'h3C);
    gamma_b_idx <= 7'h7F;
    look();
    chk(gamma_b_q, 8'h3C);
    chk(gamma_a_q, 8'h5A);
    // clock enable low must hold every register, gamma outputs included
    ce <= 1'b0;
    gamma_a_idx <= 7'h00;
    look();
    chk(gamma_a_q, 8'h5A);
    ce <= 1'b1;
    look();
    chk(gamma_a_q, 8'hA5);
    ctrl(PGCB_CTRL_RST);
    look();
    chk(link_video_mode, 1'b1);
    // a bad first key, then a bad second key, must both be dropped
    cmd(8'hFF, 8'h97);
    cmd(8'hFF, 8'h81);
    cmd(8'hFF, 8'h09);
    cmd(8'hFF, 8'h98);
    cmd(8'hFF, 8'h80);
    cmd(8'hFF, 8'h09);
    chk(cmd_page, PGCB_PAGE_B);
    pgcb_host_i.page(8'h0B);
    cmd(PGCB_GAMMA_LAST, 8'h11);
    look();
    chk(gamma_b_q, 8'h3C);
    pgcb_host_i.xfer(1'b0, PGCB_OFS_STAT, 32'h0, q, e);
    chk(q[11:0], 12'h40B);
    pgcb_host_i.xfer(1'b0, 12'h00C, 32'h0, q, e);
    chk(e, 1'b1);
    for (int i = 8; i < 14; i++) begin
      ctrl(9'(i));
      look();
      chk(zz_type, (i > 8 && i < 13) ? i - 8 : 0);
    end
    ctrl({5'h0, PGCB_ZZ_T1});
    map(1'b0, 12'd0, 12'd0, 1'b1);
    map(1'b0, 12'd2399, 12'd2399, 1'b1);
    map(1'b0, 12'd2400, 12'd0, 1'b0);
    map(1'b1, 12'd0, 12'd0, 1'b0);
    map(1'b1, 12'd1, 12'd0, 1'b1);
    map(1'b1, 12'd2400, 12'd2399, 1'b1);
    pix_x <= 10'h200;
    for (int i = 0; i < 8; i++) begin
      ctrl({2'b01, 3'(i), 4'h0});
      look();
      chk(pattern_rgb, pat[i]);
      chk(pattern_active, 1'b1);
    end
    // hardware reset in mid-run clears both tables and the page
    presetn <= 1'b0;
    look();
    presetn <= 1'b1;
    look();
    chk(gamma_a_q, PGCB_GAMMA_RST);
    chk(gamma_b_q, PGCB_GAMMA_RST);
    chk(cmd_page, PGCB_PAGE_RST);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire

// ==== pgcb_bank.sv ====
// module: paged command bank with blue fine gamma tables and panel control
`timescale 1ns/1ps
`default_nettype none
module pgcb_bank
  import pgcb_pkg::*;
#(
  parameter int N_MAIN = 2400
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [6:0]  gamma_a_idx,
  input  wire logic [6:0]  gamma_b_idx,
  output var  logic [7:0]  gamma_a_q,
  output var  logic [7:0]  gamma_b_q,
  input  wire logic [11:0] chan_idx,
  input  wire logic        gate_even,
  output var  logic [11:0] subpix_idx,
  output var  logic        subpix_vld,
  output var  logic [2:0]  zz_type,
  input  wire logic [9:0]  pix_x,
  output var  logic [23:0] pattern_rgb,
  output var  logic        pattern_active,
  output var  logic        link_video_mode,
  output var  logic [7:0]  cmd_page
);

  pgcb_pstate_t ps_ff;
  logic [7:0]   page_ff;
  pgcb_ctrl_t   ctrl_ff;
  logic [7:0]   tbl_a_ff [128];
  logic [7:0]   tbl_b_ff [128];
  logic [31:0]  rdata_ff;
  logic         err_ff;
  logic         setup_ok_ff;
  logic [7:0]   gamma_a_ff;
  logic [7:0]   gamma_b_ff;
  logic [11:0]  subpix_ff;
  logic         vld_ff;
  logic [2:0]   zz_type_ff;
  logic [23:0]  rgb_ff;
  logic         pat_ff;

  pgcb_cmd_t    cmd;
  logic         acc;
  logic         wr_cmd;
  logic         wr_ctrl;
  logic         page_rsvd;
  logic [31:0]  nxt_rdata;
  logic         nxt_err;
  logic [11:0]  nxt_subpix;
  logic         nxt_vld;
  logic [2:0]   nxt_zz_type;
  logic [23:0]  nxt_rgb;

  function automatic logic mapped(input logic [11:0] a);
    return a == PGCB_OFS_CMD || a == PGCB_OFS_CTRL || a == PGCB_OFS_STAT;
  endfunction

  function automatic logic [2:0] zz_decode(input logic [3:0] t);
    if (t >= PGCB_ZZ_T1 && t <= PGCB_ZZ_T4) begin
      return 3'(t - PGCB_ZZ_T1) + 3'h1;
    end
    return 3'h0;
  endfunction

  // apb: answer once read data is latched; a setup cycle lost to a low
  // ce costs one wait state, so stale read data is never returned
  assign pready  = ce && setup_ok_ff;
  assign acc     = psel && penable && pready;
  assign cmd     = pgcb_cmd_t'(pwdata[15:0]);
  assign wr_cmd  = acc && pwrite && paddr == PGCB_OFS_CMD;
  assign wr_ctrl = acc && pwrite && paddr == PGCB_OFS_CTRL;
  assign prdata  = rdata_ff;
  assign pslverr = err_ff && pready;

  assign page_rsvd = page_ff > PGCB_PAGE_MAX;

  always_comb begin
    nxt_rdata = 32'h0;
    nxt_err   = !mapped(paddr);
    if (!pwrite && paddr == PGCB_OFS_CTRL) begin
      nxt_rdata[8:0] = ctrl_ff;
    end else if (!pwrite && paddr == PGCB_OFS_STAT) begin
      nxt_rdata[7:0]                 = page_ff;
      nxt_rdata[PGCB_ST_STEP +: 2]   = ps_ff;
      nxt_rdata[PGCB_ST_RSVD]        = page_rsvd;
      nxt_rdata[PGCB_ST_IDLE]        = ctrl_ff.idle_mode;
    end
    if (pwrite && paddr == PGCB_OFS_STAT) begin
      nxt_err = 1'b1;
    end
  end

  // read data and error are latched in the setup cycle, or in the first
  // access cycle that follows a setup frozen by ce
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0;
      err_ff   <= 1'b0;
    end else if (ce && psel && !(penable && setup_ok_ff)) begin
      rdata_ff <= nxt_rdata;
      err_ff   <= nxt_err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_ok_ff <= 1'b0;
    end else if (ce) begin
      setup_ok_ff <= psel && !(penable && setup_ok_ff);
    end
  end

  // key sequencer; any other command aborts a half-entered sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_ff   <= PGCB_PS_IDLE;
      page_ff <= PGCB_PAGE_RST;
    end else if (wr_cmd) begin
      if (cmd.addr != PGCB_CMD_PAGE) begin
        ps_ff <= PGCB_PS_IDLE;
      end else begin
        case (ps_ff)
          PGCB_PS_IDLE: begin
            if (cmd.data == PGCB_KEY1) ps_ff <= PGCB_PS_KEY1;
          end
          PGCB_PS_KEY1: begin
            ps_ff <= (cmd.data == PGCB_KEY2) ? PGCB_PS_KEY2
                                             : PGCB_PS_IDLE;
          end
          PGCB_PS_KEY2: begin
            page_ff <= cmd.data;
            ps_ff   <= PGCB_PS_IDLE;
          end
          default: ps_ff <= PGCB_PS_IDLE;
        endcase
      end
    end
  end

  // no power-state input gates these writes: sleep and idle allow them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 128; i++) begin
        tbl_a_ff[i] <= PGCB_GAMMA_RST;
        tbl_b_ff[i] <= PGCB_GAMMA_RST;
      end
    end else if (wr_cmd && cmd.addr <= PGCB_GAMMA_LAST) begin
      if (page_ff == PGCB_PAGE_A) begin
        tbl_a_ff[cmd.addr[6:0]] <= cmd.data;
      end
      if (page_ff == PGCB_PAGE_B) begin
        tbl_b_ff[cmd.addr[6:0]] <= cmd.data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gamma_a_ff <= PGCB_GAMMA_RST;
      gamma_b_ff <= PGCB_GAMMA_RST;
    end else if (ce) begin
      gamma_a_ff <= tbl_a_ff[gamma_a_idx];
      gamma_b_ff <= tbl_b_ff[gamma_b_idx];
    end
  end
  assign gamma_a_q = gamma_a_ff;
  assign gamma_b_q = gamma_b_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= pgcb_ctrl_t'(PGCB_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_ff <= pgcb_ctrl_t'(pwdata[8:0]);
    end
  end

  // idle mode turns frames into 24bpp command-mode writes; the host
  // keeps to that format, the bank only reports which mode is live
  assign link_video_mode = !ctrl_ff.idle_mode;
  assign cmd_page        = page_ff;

  // source mapping; non-zig-zag panels leave both dummies unused
  always_comb begin
    nxt_zz_type = zz_decode(ctrl_ff.panel_shift_type);
    nxt_subpix  = chan_idx - 12'h001;
    nxt_vld     = chan_idx >= 12'h001 && chan_idx <= 12'(N_MAIN);
    if (nxt_zz_type != 3'h0 && !gate_even) begin
      nxt_subpix = chan_idx;
      nxt_vld    = chan_idx <= 12'(N_MAIN - 1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subpix_ff  <= 12'h000;
      vld_ff     <= 1'b0;
      zz_type_ff <= 3'h0;
    end else if (ce) begin
      subpix_ff  <= nxt_subpix;
      vld_ff     <= nxt_vld;
      zz_type_ff <= nxt_zz_type;
    end
  end
  assign subpix_idx = subpix_ff;
  assign subpix_vld = vld_ff;
  assign zz_type    = zz_type_ff;

  always_comb begin
    case (ctrl_ff.selftest_pattern_index)
      3'h0:    nxt_rgb = 24'hFFFFFF;
      3'h1:    nxt_rgb = 24'h000000;
      3'h2:    nxt_rgb = 24'hFF0000;
      3'h3:    nxt_rgb = 24'h00FF00;
      3'h4:    nxt_rgb = 24'h0000FF;
      3'h5:    nxt_rgb = PGCB_GRAY128;
      3'h6:    nxt_rgb = PGCB_GRAY127;
      default: nxt_rgb = {{8{~pix_x[9]}}, {8{~pix_x[8]}}, {8{~pix_x[7]}}};
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rgb_ff <= 24'h000000;
      pat_ff <= 1'b0;
    end else if (ce) begin
      rgb_ff <= ctrl_ff.builtin_pattern_test ? nxt_rgb : 24'h000000;
      pat_ff <= ctrl_ff.builtin_pattern_test;
    end
  end
  assign pattern_rgb    = rgb_ff;
  assign pattern_active = pat_ff;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  page_load_a: assert property (
    wr_cmd && cmd.addr == PGCB_CMD_PAGE && ps_ff == PGCB_PS_KEY2
    |=> page_ff == $past(cmd.data) && ps_ff == PGCB_PS_IDLE)
    else $error("page not loaded after key sequence");

  key_miss_a: assert property (
    wr_cmd && cmd.addr == PGCB_CMD_PAGE && ps_ff != PGCB_PS_KEY2
    && cmd.data != PGCB_KEY1 && cmd.data != PGCB_KEY2
    |=> $stable(page_ff) && ps_ff == PGCB_PS_IDLE)
    else $error("bad key changed page or sequencer");

  page_rsvd_a: assert property (
    acc && !pwrite && paddr == PGCB_OFS_STAT
    |-> prdata[PGCB_ST_RSVD] == (page_ff > 8'h0A))
    else $error("reserved page flag wrong");

  gamma_a_wr_a: assert property (
    wr_cmd && page_ff == 8'h09 && cmd.addr < 8'h80
    |=> tbl_a_ff[$past(cmd.addr[6:0])] == $past(cmd.data))
    else $error("page 9 gamma write lost");

  gamma_b_wr_a: assert property (
    wr_cmd && page_ff == 8'h0A && cmd.addr < 8'h80
    |=> tbl_b_ff[$past(cmd.addr[6:0])] == $past(cmd.data))
    else $error("page 10 gamma write lost");

  zz_shift_a: assert property (
    ce && zz_decode(ctrl_ff.panel_shift_type) != 3'h0 && !gate_even
    && chan_idx < 12'h960
    |=> subpix_vld && subpix_idx == $past(chan_idx))
    else $error("odd line zig-zag mapping wrong");

  chan_range_a: assert property (
    subpix_vld |-> subpix_idx < 12'h960)
    else $error("sub-pixel index past 2400 channels");

  zz_type_a: assert property (
    ce && ctrl_ff.panel_shift_type == 4'hB |=> zz_type == 3'h3)
    else $error("zig-zag type 3 not decoded");

  gray_pat_a: assert property (
    ce && ctrl_ff.builtin_pattern_test
    && ctrl_ff.selftest_pattern_index == 3'h6
    |=> pattern_active && pattern_rgb == 24'h7F7F7F)
    else $error("gray127 pattern wrong");

  idle_link_a: assert property (
    wr_ctrl && !pwdata[8] |=> link_video_mode [*2])
    else $error("link did not return to video mode");

  ce_freeze_a: assert property (
    !ce |=> $stable(page_ff) && $stable(ctrl_ff) && $stable(gamma_a_q))
    else $error("state moved while clock enable low");

endmodule
`default_nettype wire

// ==== pgcb_host.sv ====
// host model: apb master that issues configuration commands and reads
`timescale 1ns/1ps
`default_nettype none
module pgcb_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  output var  logic        tmo
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tmo = 1'b0;
  end

  // request held until pready is seen high at a rising edge, or for at most 16 edges, which sets tmo
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1)
      tmo <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // key bytes first, then the page value
  task automatic page(input logic [7:0] p);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, 12'h000, {16'h0, 8'hFF, 8'h98}, q, e);
    xfer(1'b1, 12'h000, {16'h0, 8'hFF, 8'h81}, q, e);
    xfer(1'b1, 12'h000, {16'h0, 8'hFF, p}, q, e);
  endtask
endmodule
`default_nettype wire

// ==== pgcb_pkg.sv ====
// package: constants and carrier types for the paged gamma config bank
package pgcb_pkg;
  localparam logic [7:0]  PGCB_CMD_PAGE   = 8'hFF;
  localparam logic [7:0]  PGCB_KEY1       = 8'h98;
  localparam logic [7:0]  PGCB_KEY2       = 8'h81;
  localparam logic [7:0]  PGCB_PAGE_MAX   = 8'h0A;
  localparam logic [7:0]  PGCB_PAGE_A     = 8'h09;
  localparam logic [7:0]  PGCB_PAGE_B     = 8'h0A;
  localparam logic [7:0]  PGCB_PAGE_RST   = 8'h00;
  localparam logic [7:0]  PGCB_GAMMA_RST  = 8'h00;
  localparam logic [7:0]  PGCB_GAMMA_LAST = 8'h7F;
  // apb byte offsets
  localparam logic [11:0] PGCB_OFS_CMD    = 12'h000;
  localparam logic [11:0] PGCB_OFS_CTRL   = 12'h004;
  localparam logic [11:0] PGCB_OFS_STAT   = 12'h008;
  // status field positions
  localparam int          PGCB_ST_STEP    = 8;
  localparam int          PGCB_ST_RSVD    = 10;
  localparam int          PGCB_ST_IDLE    = 11;
  // zig-zag panel type codes
  localparam logic [3:0]  PGCB_ZZ_T1      = 4'h9;
  localparam logic [3:0]  PGCB_ZZ_T4      = 4'hC;
  // self-test colours
  localparam logic [23:0] PGCB_GRAY128    = 24'h808080;
  localparam logic [23:0] PGCB_GRAY127    = 24'h7F7F7F;
  localparam logic [8:0]  PGCB_CTRL_RST   = 9'h000;

  typedef enum logic [1:0] {
    PGCB_PS_IDLE = 2'b00,
    PGCB_PS_KEY1 = 2'b01,
    PGCB_PS_KEY2 = 2'b10
  } pgcb_pstate_t;

  // command write: address in [15:8], parameter in [7:0]
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } pgcb_cmd_t;

  // control word, bits [8:0] of the control register
  typedef struct packed {
    logic       idle_mode;
    logic       builtin_pattern_test;
    logic [2:0] selftest_pattern_index;
    logic [3:0] panel_shift_type;
  } pgcb_ctrl_t;
endpackage
